/* common/mixer_pkg.sv */
// Constants and types shared by the layer mixer and its output FIFO
// ---------------------------------------------------------------
// Summary of operation
// - Hold inputs until every video header arrives
// - Read background once per unstalled ST_MIX cycle
// - Read a layer only where it covers
// - Layer N read N cycles after background
// - Any stall freezes pipeline, drops all readies
// - One alpha sample per pixel of layer
// - No frame or line storage, short latency
// - Early background end: finish current line
// - End of packet on that line's last pixel
// - Early layer end: stop reading, pad samples
// - Late end of packet enters error mode
// - Recovery after frame end realigns inputs
// - Recovery discards data, ready held high
// - Forward non-image packets in layer order
// - Stall after each frame and line
// - Consume background until its end marker
// ---------------------------------------------------------------
package mixer_pkg;

  localparam int          POS_W         = 16;
  localparam int          TYPE_W        = 4;
  localparam logic [3:0]  PKT_VIDEO     = 4'h0;
  localparam logic [2:0]  LINE_GAP_CYC  = 3'h2;
  localparam logic [2:0]  FRAME_GAP_CYC = 3'h4;
  localparam int          FIFO_DEPTH    = 4;

  typedef enum logic [2:0] {
    ST_HDR   = 3'b000,
    ST_OHDR  = 3'b001,
    ST_MIX   = 3'b011,
    ST_LGAP  = 3'b010,
    ST_DRAIN = 3'b111,
    ST_FGAP  = 3'b101,
    ST_FLUSH = 3'b110
  } mix_state_t;

endpackage

/* rtl/stream_fifo.sv */
// Small valid/ready FIFO built from flip-flops
`timescale 1ns/1ps
module stream_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = mixer_pkg::FIFO_DEPTH
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  import mixer_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0]   FULL_CNT = DEPTH[PW:0];
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [PW:0]             cnt;
  } fifo_state_t;

  fifo_state_t s_r;
  fifo_state_t s_nxt;
  logic        push;
  logic        pop;

  assign in_ready  = (s_r.cnt != FULL_CNT);
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = s_r.mem[s_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == LAST_PTR) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == LAST_PTR) ? '0 : s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

/* rtl/video_layer_mixer_flow.sv */
// Flow control and error recovery of a multi-layer video mixer
`timescale 1ns/1ps
module video_layer_mixer_flow #(
  parameter int NL = 2,
  parameter int DW = 24,
  parameter int AW = 8
) (
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic [mixer_pkg::POS_W-1:0]    cfg_width,
  input  wire logic [mixer_pkg::POS_W-1:0]    cfg_height,
  input  wire logic [NL-1:0]                 cfg_layer_en,
  input  wire logic [NL-1:0]                 cfg_alpha_en,
  input  wire logic [NL*mixer_pkg::POS_W-1:0] cfg_layer_x,
  input  wire logic [NL*mixer_pkg::POS_W-1:0] cfg_layer_y,
  input  wire logic [NL*mixer_pkg::POS_W-1:0] cfg_layer_w,
  input  wire logic [NL*mixer_pkg::POS_W-1:0] cfg_layer_h,
  input  wire logic [DW-1:0]                 bg_data,
  input  wire logic                          bg_valid,
  input  wire logic                          bg_sop,
  input  wire logic                          bg_eop,
  output logic                               bg_ready,
  input  wire logic [NL*DW-1:0]              fg_data,
  input  wire logic [NL-1:0]                 fg_valid,
  input  wire logic [NL-1:0]                 fg_sop,
  input  wire logic [NL-1:0]                 fg_eop,
  output logic [NL-1:0]                      fg_ready,
  input  wire logic [NL*AW-1:0]              al_data,
  input  wire logic [NL-1:0]                 al_valid,
  input  wire logic [NL-1:0]                 al_sop,
  input  wire logic [NL-1:0]                 al_eop,
  output logic [NL-1:0]                      al_ready,
  output logic [DW-1:0]                      out_data,
  output logic                               out_valid,
  output logic                               out_sop,
  output logic                               out_eop,
  input  wire logic                          out_ready,
  output logic                               err_flag
);
  import mixer_pkg::*;

  // ---------------------------------------------------------------
  // Input numbering: 0 background, 1..NL layers, NL+1..2NL alpha
  // ---------------------------------------------------------------
  localparam int NIN = 1 + 2 * NL;
  localparam int IW  = $clog2(NIN + 1);
  localparam logic [IW-1:0] END_IDX = IW'(NIN);

  typedef struct packed {
    logic             v;
    logic             eop;
    logic [POS_W-1:0] x;
    logic [POS_W-1:0] y;
    logic [DW-1:0]    d;
  } stage_t;

  typedef struct packed {
    mix_state_t       st;
    logic [IW-1:0]    cur;
    logic             in_fwd;
    logic [DW-1:0]    hdr;
    logic [POS_W-1:0] x;
    logic [POS_W-1:0] y;
    logic [NIN-1:0]   done;
    logic             err;
    logic             bg_short;
    logic [2:0]       gap;
    stage_t [NL:0]    pipe;
  } state_t;

  state_t              s_r;
  state_t              s_nxt;
  logic [NIN-1:0]      in_v;
  logic [NIN-1:0]      in_sop;
  logic [NIN-1:0]      in_eop;
  logic [NIN-1:0][DW-1:0] in_d;
  logic [NIN-1:0]      act;
  logic [NIN-1:0]      rdy;
  logic [NL-1:0]       cov;
  logic [NL-1:0]       wait_k;
  logic                stall;
  logic                adv;
  logic                fifo_rdy;
  logic                f_v;
  logic                f_sop;
  logic                f_eop;
  logic [DW-1:0]       f_d;
  logic                mixing;
  logic                inject;
  logic                bg_need;
  logic                last_x;
  logic                last_y;

  // ---------------------------------------------------------------
  // Per-layer packing, coverage test and input wait
  // ---------------------------------------------------------------
  assign in_v[0]   = bg_valid;
  assign in_sop[0] = bg_sop;
  assign in_eop[0] = bg_eop;
  assign in_d[0]   = bg_data;
  assign act[0]    = 1'b1;

  for (genvar k = 0; k < NL; k++) begin : g_layer
    logic [POS_W-1:0] lx;
    logic [POS_W-1:0] ly;
    logic [POS_W:0]   xe;
    logic [POS_W:0]   ye;
    assign lx = cfg_layer_x[k*POS_W +: POS_W];
    assign ly = cfg_layer_y[k*POS_W +: POS_W];
    assign xe = {1'b0, lx} + {1'b0, cfg_layer_w[k*POS_W +: POS_W]};
    assign ye = {1'b0, ly} + {1'b0, cfg_layer_h[k*POS_W +: POS_W]};

    assign in_v[1+k]      = fg_valid[k];
    assign in_sop[1+k]    = fg_sop[k];
    assign in_eop[1+k]    = fg_eop[k];
    assign in_d[1+k]      = fg_data[k*DW +: DW];
    assign in_v[1+NL+k]   = al_valid[k];
    assign in_sop[1+NL+k] = al_sop[k];
    assign in_eop[1+NL+k] = al_eop[k];
    assign in_d[1+NL+k]   = DW'(al_data[k*AW +: AW]);
    assign act[1+k]       = cfg_layer_en[k];
    assign act[1+NL+k]    = cfg_layer_en[k] && cfg_alpha_en[k];

    // Layer k is read with the pixel held in stage k
    assign cov[k] = s_r.pipe[k].v && cfg_layer_en[k] &&
                    (s_r.pipe[k].x >= lx) && ({1'b0, s_r.pipe[k].x} < xe) &&
                    (s_r.pipe[k].y >= ly) &&
                    ({1'b0, s_r.pipe[k].y} < ye);
    assign wait_k[k] = cov[k] &&
                       ((!s_r.done[1+k] && !in_v[1+k]) ||
                        (act[1+NL+k] && !s_r.done[1+NL+k] &&
                         !in_v[1+NL+k]));
  end

  // ---------------------------------------------------------------
  // Global stall of the mixing pipeline
  // ---------------------------------------------------------------
  assign mixing  = (s_r.st == ST_MIX) || (s_r.st == ST_LGAP) ||
                   (s_r.st == ST_DRAIN);
  assign inject  = (s_r.st == ST_MIX);
  assign bg_need = inject && !s_r.done[0];
  assign stall   = (s_r.pipe[NL].v && !fifo_rdy) ||
                   (bg_need && !bg_valid) || (|wait_k);
  assign adv     = mixing && !stall;
  assign last_x  = ({1'b0, s_r.x} + 17'h00001) == {1'b0, cfg_width};
  assign last_y  = ({1'b0, s_r.y} + 17'h00001) == {1'b0, cfg_height};

  assign bg_ready = rdy[0];
  assign fg_ready = rdy[NL:1];
  assign al_ready = rdy[2*NL:NL+1];
  assign err_flag = s_r.err;

  function automatic logic [IW-1:0] next_act(
    input logic [IW-1:0]  c,
    input logic [NIN-1:0] a
  );
    logic [IW-1:0] r;
    r = END_IDX;
    for (int i = NIN - 1; i >= 0; i--) begin
      if (a[i] && (IW'(i) > c)) begin
        r = IW'(i);
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic take;
    logic early;
    logic short_now;
    logic [DW-1:0] fgd;
    take      = 1'b0;
    early     = 1'b0;
    short_now = 1'b0;
    fgd       = '0;
    s_nxt     = s_r;
    rdy       = '0;
    f_v       = 1'b0;
    f_sop     = 1'b0;
    f_eop     = 1'b0;
    f_d       = '0;
    unique case (s_r.st)
      ST_HDR: begin
        if (s_r.cur == END_IDX) begin
          s_nxt.st = ST_OHDR;
        end else if (s_r.in_fwd) begin
          rdy[s_r.cur] = fifo_rdy;
          f_v   = in_v[s_r.cur];
          f_d   = in_d[s_r.cur];
          f_eop = in_eop[s_r.cur];
          if (in_v[s_r.cur] && fifo_rdy && in_eop[s_r.cur]) begin
            s_nxt.in_fwd = 1'b0;
          end
        end else if (in_v[s_r.cur] && in_sop[s_r.cur] &&
                     in_d[s_r.cur][TYPE_W-1:0] == PKT_VIDEO) begin
          // Header taken; this input is held off until the frame starts
          rdy[s_r.cur] = 1'b1;
          if (s_r.cur == '0) begin
            s_nxt.hdr = in_d[0];
          end
          s_nxt.cur = next_act(s_r.cur, act);
        end else if (in_v[s_r.cur] && in_sop[s_r.cur]) begin
          rdy[s_r.cur] = fifo_rdy;
          f_v   = 1'b1;
          f_sop = 1'b1;
          f_d   = in_d[s_r.cur];
          f_eop = in_eop[s_r.cur];
          if (fifo_rdy && !in_eop[s_r.cur]) begin
            s_nxt.in_fwd = 1'b1;
          end
        end else begin
          // Stray beats outside any packet are dropped
          rdy[s_r.cur] = 1'b1;
        end
      end

      ST_OHDR: begin
        f_v   = 1'b1;
        f_sop = 1'b1;
        f_d   = s_r.hdr;
        if (fifo_rdy) begin
          s_nxt.st       = ST_MIX;
          s_nxt.x        = '0;
          s_nxt.y        = '0;
          s_nxt.done     = '0;
          s_nxt.err      = 1'b0;
          s_nxt.bg_short = 1'b0;
        end
      end

      ST_MIX, ST_LGAP, ST_DRAIN: begin
        if (adv) begin
          // Output beat leaves the last stage
          f_v   = s_r.pipe[NL].v;
          f_eop = s_r.pipe[NL].eop;
          f_d   = s_r.pipe[NL].d;
          rdy[0] = bg_need;
          early  = bg_need && bg_valid && bg_eop && !(last_x && last_y);
          short_now = s_r.bg_short || early;
          if (early) begin
            s_nxt.bg_short = 1'b1;
            s_nxt.err      = 1'b1;
          end
          for (int k = 0; k < NL; k++) begin
            s_nxt.pipe[k+1] = s_r.pipe[k];
            rdy[1+k]    = cov[k] && !s_r.done[1+k];
            rdy[1+NL+k] = cov[k] && act[1+NL+k] &&
                          !s_r.done[1+NL+k];
            if (cov[k]) begin
              fgd  = s_r.done[1+k] ? '0 : in_d[1+k];
              take = !act[1+NL+k] ||
                     (!s_r.done[1+NL+k] && in_d[1+NL+k][AW-1]);
              if (take) begin
                s_nxt.pipe[k+1].d = fgd;
              end
            end
          end
          // Background pixel enters stage 0, padded once the packet ended
          s_nxt.pipe[0] = '0;
          if (inject) begin
            s_nxt.pipe[0].v   = 1'b1;
            s_nxt.pipe[0].x   = s_r.x;
            s_nxt.pipe[0].y   = s_r.y;
            s_nxt.pipe[0].d   = bg_need ? bg_data : '0;
            s_nxt.pipe[0].eop = last_x && (last_y || short_now);
            if (last_x) begin
              s_nxt.x = '0;
              s_nxt.y = s_r.y + 1'b1;
              if (last_y || short_now) begin
                s_nxt.st = ST_DRAIN;
              end else begin
                s_nxt.st  = ST_LGAP;
                s_nxt.gap = LINE_GAP_CYC;
              end
            end else begin
              s_nxt.x = s_r.x + 1'b1;
            end
          end
          // Any end of packet stops further reads of that input
          for (int i = 0; i < NIN; i++) begin
            if (rdy[i] && in_v[i] && in_eop[i]) begin
              s_nxt.done[i] = 1'b1;
            end
          end
        end
        if (s_r.st == ST_LGAP) begin
          if (s_r.gap <= 3'h1) begin
            s_nxt.st = ST_MIX;
          end else begin
            s_nxt.gap = s_r.gap - 1'b1;
          end
        end
        if (s_r.st == ST_DRAIN && !(|s_r.pipe[0].v) && !stall) begin
          take = 1'b1;
          for (int k = 0; k <= NL; k++) begin
            if (s_r.pipe[k].v) begin
              take = 1'b0;
            end
          end
          if (take) begin
            if (|(act & ~s_nxt.done)) begin
              s_nxt.err = 1'b1;
              s_nxt.st  = ST_FLUSH;
            end else begin
              s_nxt.st  = ST_FGAP;
              s_nxt.gap = FRAME_GAP_CYC;
            end
          end
        end
      end

      ST_FLUSH: begin
        // Discard every unfinished input up to its end marker
        for (int i = 0; i < NIN; i++) begin
          if (act[i] && !s_r.done[i]) begin
            rdy[i] = 1'b1;
            if (in_v[i] && in_eop[i]) begin
              s_nxt.done[i] = 1'b1;
            end
          end
        end
        if (!(|(act & ~s_nxt.done))) begin
          s_nxt.st  = ST_FGAP;
          s_nxt.gap = FRAME_GAP_CYC;
        end
      end

      ST_FGAP: begin
        if (s_r.gap <= 3'h1) begin
          s_nxt.st     = ST_HDR;
          s_nxt.cur    = '0;
          s_nxt.in_fwd = 1'b0;
        end else begin
          s_nxt.gap = s_r.gap - 1'b1;
        end
      end

      default: begin
        s_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Output FIFO
  // ---------------------------------------------------------------
  logic [DW+1:0] fo_data;

  stream_fifo #(
    .W     (DW + 2),
    .DEPTH (FIFO_DEPTH)
  ) u_out_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (f_v),
    .in_ready  (fifo_rdy),
    .in_data   ({f_sop, f_eop, f_d}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fo_data)
  );

  assign out_sop  = fo_data[DW+1];
  assign out_eop  = fo_data[DW];
  assign out_data = fo_data[DW-1:0];

endmodule

/* verif/video_layer_mixer_flow_assertions.sv */
// Concurrent checks on the mixer's stream ports
`timescale 1ns/1ps
module video_layer_mixer_flow_assertions #(
  parameter int NL = 2,
  parameter int DW = 24
) (
  input wire logic          mclk,
  input wire logic          rst,
  input wire logic [NL-1:0] cfg_layer_en,
  input wire logic [NL-1:0] cfg_alpha_en,
  input wire logic [DW-1:0] bg_data,
  input wire logic          bg_valid,
  input wire logic          bg_sop,
  input wire logic          bg_eop,
  input wire logic          bg_ready,
  input wire logic [NL-1:0] fg_valid,
  input wire logic [NL-1:0] fg_sop,
  input wire logic [NL-1:0] fg_ready,
  input wire logic [NL-1:0] al_valid,
  input wire logic [NL-1:0] al_ready,
  input wire logic [DW-1:0] out_data,
  input wire logic          out_valid,
  input wire logic          out_sop,
  input wire logic          out_eop,
  input wire logic          out_ready,
  input wire logic          err_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Set while the background is inside a video packet
  logic vid_r;
  wire  bg_x = bg_valid && bg_ready;
  wire  [NL-1:0] fg_x = fg_valid & fg_ready & ~fg_sop;
  always_ff @(posedge mclk) begin
    if (rst) vid_r <= 1'b0;
    else if (bg_x && bg_sop) vid_r <= bg_data[3:0] == mixer_pkg::PKT_VIDEO;
    else if (bg_x && bg_eop) vid_r <= 1'b0;
  end
  // Pixels taken since the output last moved; pipe plus FIFO bound them
  localparam int HOLD_MAX = mixer_pkg::FIFO_DEPTH + NL + 1;
  logic [3:0] bg_held_r;
  logic [4:0] fg_held_r;
  always_ff @(posedge mclk) begin
    if (rst || (out_valid && out_ready)) begin
      bg_held_r <= 4'h0;
      fg_held_r <= 5'h00;
    end else begin
      if (bg_x && vid_r && !bg_sop && !err_flag && bg_held_r != 4'hF) begin
        bg_held_r <= bg_held_r + 4'h1;
      end
      if ((|fg_x) && !err_flag && fg_held_r != 5'h1F) begin
        fg_held_r <= fg_held_r + 5'h01;
      end
    end
  end
  property p_out_hold;
    out_valid && !out_ready |=> out_valid && $stable({out_data, out_eop});
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("beat not held");
  property p_alpha_pair;
    !err_flag |-> (fg_x & cfg_alpha_en & ~(al_valid & al_ready)) == '0;
  endproperty
  a_alpha_pair: assert property (p_alpha_pair)
    else $error("alpha unpaired");
  property p_no_dis_fg;
    (fg_ready & ~cfg_layer_en) == '0;
  endproperty
  a_no_dis_fg: assert property (p_no_dis_fg)
    else $error("off layer read");
  property p_no_dis_al;
    (al_ready & ~cfg_alpha_en) == '0;
  endproperty
  a_no_dis_al: assert property (p_no_dis_al)
    else $error("off alpha read");
  property p_bg_gap;
    vid_r && bg_x && bg_eop |=> !bg_ready [*2];
  endproperty
  a_bg_gap: assert property (p_bg_gap) else $error("no frame gap");
  property p_pix_lat;
    vid_r && bg_x && !bg_sop && !err_flag |-> ##[1:8] out_valid;
  endproperty
  a_pix_lat: assert property (p_pix_lat) else $error("latency too long");
  property p_stall_bg;
    bg_held_r <= HOLD_MAX;
  endproperty
  a_stall_bg: assert property (p_stall_bg) else $error("bg not stalled");
  property p_stall_fg;
    fg_held_r <= HOLD_MAX * NL;
  endproperty
  a_stall_fg: assert property (p_stall_fg) else $error("fg not stalled");
endmodule

bind video_layer_mixer_flow video_layer_mixer_flow_assertions #(
  .NL(NL), .DW(DW)) u_chk (.mclk, .rst, .cfg_layer_en, .cfg_alpha_en,
  .bg_data, .bg_valid, .bg_sop, .bg_eop, .bg_ready, .fg_valid, .fg_sop,
  .fg_ready, .al_valid, .al_ready, .out_data, .out_valid, .out_sop,
  .out_eop, .out_ready, .err_flag);

/* verif/stream_source.sv */
// Upstream stream source model fed from a beat queue
`timescale 1ns/1ps
module stream_source #(
  parameter int W = 24
) (
  input  wire logic    mclk,
  input  wire logic    rst,
  input  wire logic    slow,
  output logic         valid,
  output logic         sop,
  output logic         eop,
  output logic [W-1:0] data,
  input  wire logic    ready
);
  logic [W+1:0] q[$];
  logic         tick = 1'b0;
  task automatic push(input logic s, input logic e, input logic [W-1:0] d);
    q.push_back({s, e, d});
  endtask
  initial {valid, sop, eop, data} = '0;
  always @(posedge mclk) begin
    tick <= !tick;
    if (rst) valid <= 1'b0;
    else if (!valid || ready) begin
      if (valid) q.delete(0);
      if (q.size() > 0 && !(slow && tick)) begin
        {valid, sop, eop, data} <= {1'b1, q[0]};
      end else begin
        // Released lines invert each idle cycle, showing the old beat every second cycle
        {valid, sop, eop, data} <= {1'b0, ~sop, ~eop, ~data};
      end
    end
  end
endmodule

/* verif/video_layer_mixer_flow_tb.sv */
// Self-checking bench for the layer mixer flow control
`timescale 1ns/1ps
module video_layer_mixer_flow_tb;
  import mixer_pkg::*;
  localparam int NL = 2;
  localparam int DW = 24;
  localparam int AW = 8;
  localparam int W  = 4;
  logic                mclk = 1'b0;
  logic                rst = 1'b1;
  logic                slow = 1'b0;
  logic                out_ready = 1'b0;
  logic [3:0]          cnt = 4'h0;
  logic [POS_W-1:0]    cfg_width = 16'h4;
  logic [POS_W-1:0]    cfg_height = 16'h1;
  logic [NL-1:0]       cfg_layer_en = 2'h0;
  logic [NL-1:0]       cfg_alpha_en = 2'h0;
  logic [NL*POS_W-1:0] cfg_layer_x = 32'h1;
  logic [NL*POS_W-1:0] cfg_layer_y = 32'h0;
  logic [NL*POS_W-1:0] cfg_layer_w = 32'h2;
  logic [NL*POS_W-1:0] cfg_layer_h = 32'h1;
  wire  [DW-1:0]       bg_data;
  wire                 bg_valid, bg_sop, bg_eop, bg_ready;
  wire  [NL*DW-1:0]    fg_data;
  wire  [NL-1:0]       fg_valid, fg_sop, fg_eop, fg_ready;
  wire  [NL*AW-1:0]    al_data;
  wire  [NL-1:0]       al_valid, al_sop, al_eop, al_ready;
  wire  [DW-1:0]       out_data;
  wire                 out_valid, out_sop, out_eop, err_flag;
  logic [DW+1:0]       got[$];
  int                  errors = 0;
  int                  n_compared = 0;

  initial forever #50 mclk = ~mclk;
  // Sink: collects beats, long stalls when slow
  always @(posedge mclk) begin
    if (out_valid && out_ready) got.push_back({out_sop, out_eop, out_data});
    cnt <= cnt + 4'h1;
    out_ready <= !slow || cnt[3:2] == 2'h3;
  end

  stream_source #(.W(DW)) u_bg (.mclk, .rst, .slow, .valid(bg_valid),
    .sop(bg_sop), .eop(bg_eop), .data(bg_data), .ready(bg_ready));
  for (genvar k = 0; k < NL; k++) begin : g_src
    stream_source #(.W(DW)) u_fg (.mclk, .rst, .slow, .valid(fg_valid[k]),
      .sop(fg_sop[k]), .eop(fg_eop[k]), .data(fg_data[k*DW+:DW]),
      .ready(fg_ready[k]));
    stream_source #(.W(AW)) u_al (.mclk, .rst, .slow, .valid(al_valid[k]),
      .sop(al_sop[k]), .eop(al_eop[k]), .data(al_data[k*AW+:AW]),
      .ready(al_ready[k]));
  end

  video_layer_mixer_flow #(.NL(NL), .DW(DW), .AW(AW)) u_dut (.mclk, .rst,
    .cfg_width, .cfg_height, .cfg_layer_en, .cfg_alpha_en, .cfg_layer_x,
    .cfg_layer_y, .cfg_layer_w, .cfg_layer_h, .bg_data, .bg_valid, .bg_sop,
    .bg_eop, .bg_ready, .fg_data, .fg_valid, .fg_sop, .fg_eop, .fg_ready,
    .al_data, .al_valid, .al_sop, .al_eop, .al_ready, .out_data, .out_valid,
    .out_sop, .out_eop, .out_ready, .err_flag);

  task automatic final_report;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: seen %0h want %0h", $time, seen, want);
    end
  endtask

  // ---------------------------------------------------------------
  // One frame: stimulus, wait, expected beats from the frame geometry
  // ---------------------------------------------------------------
  task automatic run_frame(input int h, input int bg_n, input int fg_n,
                           input logic le, input logic ae, input logic ctl);
    int            k;
    int            x;
    int            o;
    int            n_exp;
    logic          exp_err;
    logic [DW-1:0] v;
    cfg_height   <= h[POS_W-1:0];
    cfg_layer_en <= {1'b0, le};
    cfg_alpha_en <= {1'b0, ae};
    got.delete();
    o = ctl ? 3 : 1;
    n_exp = bg_n < h * W ? ((bg_n - 1) / W + 1) * W : h * W;
    exp_err = bg_n != h * W || (le && fg_n > 2);
    if (ctl) begin
      u_bg.push(1'b1, 1'b0, 24'h000031);
      u_bg.push(1'b0, 1'b1, 24'h000777);
    end
    u_bg.push(1'b1, 1'b0, 24'h000A50);
    for (k = 0; k < bg_n; k++)
      u_bg.push(1'b0, k == bg_n - 1, 24'(k + 'h100000));
    if (le) begin
      g_src[0].u_fg.push(1'b1, 1'b0, 24'h000A50);
      for (k = 0; k < fg_n; k++)
        g_src[0].u_fg.push(1'b0, k == fg_n - 1, 24'(k + 'h200000));
    end
    if (ae) begin
      g_src[0].u_al.push(1'b1, 1'b0, 8'h00);
      g_src[0].u_al.push(1'b0, 1'b0, 8'h80);
      g_src[0].u_al.push(1'b0, 1'b1, 8'h80);
    end
    for (k = 0; k < 900 && got.size() < n_exp + o; k++) @(posedge mclk);
    if (got.size() < n_exp + o) begin
      errors++;
      final_report();
    end
    repeat (30) @(posedge mclk);
    check(got.size(), n_exp + o);
    if (ctl) begin
      check(got[0], {2'h2, 24'h000031});
      check(got[1], {2'h1, 24'h000777});
    end
    check(got[o - 1], {2'h2, 24'h000A50});
    for (k = 0; k < n_exp; k++) begin
      x = k % W;
      v = k < bg_n ? 24'(k + 'h100000) : 24'h0;
      if (le && k < W && x >= 1 && x < 3)
        v = x - 1 < fg_n ? 24'(x + 'h1FFFFF) : 24'h0;
      check(got[o + k], {1'b0, k == n_exp - 1, v});
    end
    check(err_flag, exp_err);
    check(u_bg.q.size() + g_src[0].u_fg.q.size(), 0);
    check(g_src[0].u_al.q.size(), 0);
  endtask

  task automatic t_plain;
    run_frame(2, 8, 2, 1'b1, 1'b1, 1'b1);
  endtask
  task automatic t_stall;
    slow <= 1'b1;
    run_frame(2, 8, 2, 1'b1, 1'b1, 1'b0);
    slow <= 1'b0;
  endtask
  task automatic t_no_layer;
    run_frame(1, 4, 0, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_early_bg;
    run_frame(2, 5, 2, 1'b1, 1'b1, 1'b0);
  endtask
  task automatic t_late_bg;
    run_frame(2, 10, 2, 1'b1, 1'b1, 1'b0);
  endtask
  task automatic t_early_fg;
    run_frame(1, 4, 1, 1'b1, 1'b0, 1'b0);
  endtask
  task automatic t_late_fg;
    run_frame(1, 4, 3, 1'b1, 1'b1, 1'b0);
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_plain();
    t_stall();
    t_early_bg();
    t_late_bg();
    t_no_layer();
    t_early_fg();
    t_late_fg();
    t_plain();
    final_report();
  end
endmodule
